// >>> design/pcs_pkg.sv
// constants and types shared by the completion status block
package pcs_pkg;
    localparam int unsigned ADDR_W        = 16;
    localparam int unsigned DATA_W        = 32;
    // register byte addresses
    localparam logic [15:0] OFS_STATUS    = 16'h2020;
    localparam logic [15:0] OFS_HALT      = 16'h2024;
    localparam logic [15:0] OFS_CTRL      = 16'h2004;
    localparam logic [15:0] OFS_IRQ_STAT  = 16'h2030;
    localparam logic [15:0] OFS_IRQ_MASK  = 16'h2034;
    // field positions
    localparam int unsigned DONE_BIT      = 0;
    localparam int unsigned PIN_EN_BIT    = 8;
    localparam int unsigned CAUSE_W       = 4;
    // reset values
    localparam logic        DONE_RST      = 1'b0;
    localparam logic [3:0]  CAUSE_RST     = 4'h0;
    localparam logic        PIN_EN_RST    = 1'b0;
    localparam logic [1:0]  IRQ_RST       = 2'h0;
    // interrupt status bits
    localparam int unsigned EV_DONE       = 0;
    localparam int unsigned EV_FAULT      = 1;
    localparam int unsigned EV_N          = 2;

    typedef enum logic [3:0] {
        PCS_CAUSE_NORMAL  = 4'h0,
        PCS_CAUSE_ABORT   = 4'h1,
        PCS_CAUSE_NO_INV  = 4'h2,
        PCS_CAUSE_NOT_CRV = 4'h3,
        PCS_CAUSE_BAD_UC  = 4'h4
    } pcs_cause_t;
endpackage : pcs_pkg

// >>> design/pcs_reg_if.sv
// internal carrier between bus slave and status core
`timescale 1ns/100ps
`default_nettype none
interface pcs_reg_if;
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [3:0]  sel;
    logic [31:0] rdata;
    logic        hit;
    modport slave (output wr, output rd, output addr, output wdata,
                   output sel, input rdata, input hit);
    modport core  (input wr, input rd, input addr, input wdata,
                   input sel, output rdata, output hit);
endinterface : pcs_reg_if
`default_nettype wire

// >>> design/pcs_wb_slave.sv
// classic wishbone slave front end, one wait state
`timescale 1ns/100ps
`default_nettype none
module pcs_wb_slave (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             err_o,
    // core side
    pcs_reg_if.slave         rif
);
    logic        ack_r;
    logic        ack_nxt;
    logic        err_r;
    logic        err_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic        req;

    // ack after access, never two in a row for one held request
    assign req       = cyc_i && stb_i && !ack_r && !err_r;
    assign rif.wr    = req && we_i && rif.hit;
    assign rif.rd    = req && !we_i && rif.hit;
    assign rif.addr  = adr_i;
    assign rif.wdata = dat_i;
    assign rif.sel   = sel_i;

    always_comb begin
        ack_nxt = req && rif.hit;
        err_nxt = req && !rif.hit;
        dat_nxt = (req && !we_i && rif.hit) ? rif.rdata : 32'h0000_0000;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign ack_o = ack_r;
    assign err_o = err_r;
    assign dat_o = dat_r;
endmodule : pcs_wb_slave
`default_nettype wire

// >>> design/pcs_status_core.sv
// completion flag, halt cause and interrupt logic
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - finishing an operation sets the done flag, held until cleared
// - writing one to the done flag clears it; zero leaves it alone
// - interrupt pin high while done flag set and interrupt enabled
// - clearing the done flag by writing one also drops the interrupt pin irq_ext_o; irq_o follows the event bits
// - four-bit read-only stop reason: normal, abort, no inverse, curve, code
// - nonzero stop reason means the result is invalid
// - interrupt enable gates only the pin, never the status contents
module pcs_status_core (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // engine side
    input  wire logic        op_done_i,
    input  wire logic [3:0]  op_cause_i,
    // register access
    pcs_reg_if.core          rif,
    // status outputs
    output logic             done_o,
    output logic             result_valid_o,
    output logic             irq_o,
    output logic             irq_ext_o
);
    logic       done_r;
    logic       done_nxt;
    logic [3:0] cause_r;
    logic [3:0] cause_nxt;
    logic       pin_en_r;
    logic       pin_en_nxt;
    logic [1:0] ist_r;
    logic [1:0] ist_nxt;
    logic [1:0] imask_r;
    logic [1:0] imask_nxt;
    logic       wr_stat;
    logic       wr_ctrl;
    logic       wr_ist;
    logic       wr_imask;
    logic [1:0] ev;

    assign wr_stat  = rif.wr && rif.sel[0] && rif.addr == pcs_pkg::OFS_STATUS;
    assign wr_ctrl  = rif.wr && rif.sel[1] && rif.addr == pcs_pkg::OFS_CTRL;
    assign wr_ist   = rif.wr && rif.sel[0]
                      && rif.addr == pcs_pkg::OFS_IRQ_STAT;
    assign wr_imask = rif.wr && rif.sel[0]
                      && rif.addr == pcs_pkg::OFS_IRQ_MASK;
    assign ev[pcs_pkg::EV_DONE]  = op_done_i;
    assign ev[pcs_pkg::EV_FAULT] = op_done_i && op_cause_i != 4'h0;

    always_comb begin
        done_nxt  = done_r;
        cause_nxt = cause_r;
        pin_en_nxt = pin_en_r;
        imask_nxt = imask_r;
        if (wr_stat && rif.wdata[pcs_pkg::DONE_BIT]) begin
            done_nxt = 1'b0;
        end
        if (op_done_i) begin
            done_nxt  = 1'b1;
            cause_nxt = op_cause_i;
        end
        if (wr_ctrl) begin
            pin_en_nxt = rif.wdata[pcs_pkg::PIN_EN_BIT];
        end
        if (wr_imask) begin
            imask_nxt = rif.wdata[1:0];
        end
        ist_nxt = ist_r;
        if (wr_ist) begin
            ist_nxt = ist_r & ~rif.wdata[1:0];
        end
        ist_nxt = ist_nxt | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_r  <= pcs_pkg::DONE_RST;
            cause_r <= pcs_pkg::CAUSE_RST;
            pin_en_r <= pcs_pkg::PIN_EN_RST;
            ist_r   <= pcs_pkg::IRQ_RST;
            imask_r <= pcs_pkg::IRQ_RST;
        end else begin
            done_r  <= done_nxt;
            cause_r <= cause_nxt;
            pin_en_r <= pin_en_nxt;
            ist_r   <= ist_nxt;
            imask_r <= imask_nxt;
        end
    end

    // read mux; reserved bits read zero
    always_comb begin
        rif.hit   = 1'b1;
        rif.rdata = 32'h0000_0000;
        unique case (rif.addr)
            pcs_pkg::OFS_STATUS:   rif.rdata[pcs_pkg::DONE_BIT] = done_r;
            pcs_pkg::OFS_HALT:     rif.rdata[3:0] = cause_r;
            pcs_pkg::OFS_CTRL:     rif.rdata[pcs_pkg::PIN_EN_BIT] = pin_en_r;
            pcs_pkg::OFS_IRQ_STAT: rif.rdata[1:0] = ist_r;
            pcs_pkg::OFS_IRQ_MASK: rif.rdata[1:0] = imask_r;
            default:               rif.hit = 1'b0;
        endcase
    end

    assign done_o = done_r;
    assign result_valid_o = done_r && cause_r == 4'h0;
    assign irq_ext_o = done_r && pin_en_r;
    assign irq_o     = |(ist_r & imask_r);
endmodule : pcs_status_core
`default_nettype wire

// >>> design/pcs_top.sv
// top of the completion status register bank
`timescale 1ns/100ps
`default_nettype none
module pcs_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             err_o,
    // engine
    input  wire logic        op_done_i,
    input  wire logic [3:0]  op_cause_i,
    // status
    output logic             done_o,
    output logic             result_valid_o,
    output logic             irq_o,
    output logic             irq_ext_o
);
    pcs_reg_if rif ();

    pcs_wb_slave u_bus (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cyc_i (cyc_i),
        .stb_i (stb_i),
        .we_i  (we_i),
        .adr_i (adr_i),
        .dat_i (dat_i),
        .sel_i (sel_i),
        .dat_o (dat_o),
        .ack_o (ack_o),
        .err_o (err_o),
        .rif   (rif.slave)
    );

    pcs_status_core u_core (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .op_done_i      (op_done_i),
        .op_cause_i     (op_cause_i),
        .rif            (rif.core),
        .done_o         (done_o),
        .result_valid_o (result_valid_o),
        .irq_o          (irq_o),
        .irq_ext_o      (irq_ext_o)
    );
endmodule : pcs_top
`default_nettype wire

// >>> tb/pcs_props.sv
// port assertions for the completion status block
`timescale 1ns/100ps
`default_nettype none
module pcs_props (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        ack_o,
    input  wire logic        err_o,
    // engine and status
    input  wire logic        op_done_i,
    input  wire logic [3:0]  op_cause_i,
    input  wire logic        done_o,
    input  wire logic        result_valid_o,
    input  wire logic        irq_ext_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take_w;
    logic clr_w;
    assign take_w = cyc_i && stb_i && !ack_o && !err_o;
    assign clr_w = take_w && we_i && adr_i == pcs_pkg::OFS_STATUS
                   && sel_i[0] && dat_i[pcs_pkg::DONE_BIT];
    // a completion pulse outranks a clear in the same cycle
    sequence s_clr;
        clr_w && !op_done_i;
    endsequence
    a_ack_once: assert property (take_w |=> (ack_o ^ err_o))
        else $error("bus request not answered once");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_done_set: assert property (op_done_i |=> done_o)
        else $error("done flag not set");
    a_done_hold: assert property (done_o && !clr_w |=> done_o)
        else $error("done flag lost");
    a_clr_done: assert property (s_clr |=> !done_o)
        else $error("done flag not cleared");
    a_clr_irq: assert property (s_clr |=> !irq_ext_o)
        else $error("interrupt not dropped");
    a_irq_gate: assert property (irq_ext_o |-> done_o)
        else $error("interrupt without done flag");
    a_cause_valid: assert property (op_done_i |=>
        result_valid_o == ($past(op_cause_i) == 4'h0))
        else $error("result valid disagrees with cause");
endmodule // pcs_props
bind pcs_top pcs_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .ack_o(ack_o), .err_o(err_o), .op_done_i(op_done_i),
    .op_cause_i(op_cause_i), .done_o(done_o),
    .result_valid_o(result_valid_o), .irq_ext_o(irq_ext_o));
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the completion status block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, op_done_i, berr;
    logic        ack_o, err_o, done_o, result_valid_o, irq_o, irq_ext_o;
    logic [15:0] adr_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [3:0]  sel_i, op_cause_i;
    int          n_fail, checks_done;

    always #12.5 clk_i = ~clk_i;

    pcs_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
        .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .op_done_i(op_done_i),
        .op_cause_i(op_cause_i), .done_o(done_o),
        .result_valid_o(result_valid_o), .irq_o(irq_o),
        .irq_ext_o(irq_ext_o));

    task automatic summarize;
        if (n_fail == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    // request held until the rising edge that samples the answer high
    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [31:0] d, input logic [3:0] s = 4'hf);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 20);
        rd   = dat_o;
        berr = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1 && err_o !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t bus answer timeout", $time);
            summarize();
        end
    endtask

    task automatic fire(input logic [3:0] c);
        @(posedge clk_i);
        op_done_i  <= 1'b1;
        op_cause_i <= c;
        @(posedge clk_i);
        op_done_i  <= 1'b0;
    endtask

    task automatic t_reset;
        wb(1'b0, 16'h2020, 32'h0);
        chk(rd, 32'h0, "status reset");
        wb(1'b0, 16'h2024, 32'h0);
        chk(rd, 32'h0, "cause reset");
        wb(1'b0, 16'h2004, 32'h0);
        chk(rd, 32'h0, "control reset");
        chk({done_o, irq_ext_o, irq_o}, 3'h0, "outputs at reset");
    endtask

    task automatic t_done_irq;
        fire(4'h0);
        @(negedge clk_i);
        chk(done_o, 1'b1, "done set");
        chk(result_valid_o, 1'b1, "normal result valid");
        chk(irq_ext_o, 1'b0, "pin gated off");
        wb(1'b1, 16'h2020, 32'h0);
        wb(1'b0, 16'h2020, 32'h0);
        chk(rd, 32'h1, "zero write kept flag");
        wb(1'b1, 16'h2004, 32'h100);
        @(negedge clk_i);
        chk(irq_ext_o, 1'b1, "pin raised");
        wb(1'b1, 16'h2004, 32'h0);
        wb(1'b0, 16'h2020, 32'h0);
        chk(rd, 32'h1, "enable left flag");
        wb(1'b1, 16'h2004, 32'h100);
        wb(1'b1, 16'h2020, 32'h1);
        @(negedge clk_i);
        chk(done_o, 1'b0, "flag cleared");
        chk(irq_ext_o, 1'b0, "pin acknowledged");
    endtask

    task automatic t_causes;
        for (int c = 1; c <= 4; c++) begin
            fire(c[3:0]);
            @(negedge clk_i);
            chk(result_valid_o, 1'b0, "fault result invalid");
            chk(irq_ext_o, 1'b1, "pin on fault stop");
            wb(1'b0, 16'h2024, 32'h0);
            chk(rd, c, "stop reason");
            wb(1'b1, 16'h2020, 32'h1);
        end
    endtask

    task automatic t_sticky;
        wb(1'b1, 16'h2034, 32'h3);
        wb(1'b1, 16'h2030, 32'h3);
        @(negedge clk_i);
        chk(irq_o, 1'b0, "events cleared");
        fire(4'h3);
        @(negedge clk_i);
        chk(irq_o, 1'b1, "unmasked event");
        wb(1'b0, 16'h2030, 32'h0);
        chk(rd, 32'h3, "event bits");
        wb(1'b1, 16'h2030, 32'h3);
        wb(1'b1, 16'h2034, 32'h0);
        fire(4'h0);
        @(negedge clk_i);
        chk(irq_o, 1'b0, "masked event");
        wb(1'b1, 16'h2020, 32'h1, 4'he);
        chk(done_o, 1'b1, "lane off write ignored");
        wb(1'b1, 16'h2100, 32'hffff_ffff);
        chk(berr, 1'b1, "unmapped refused");
        chk(done_o, 1'b1, "unmapped no effect");
    endtask

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, op_done_i} = 4'h0;
        adr_i = 16'h0;
        dat_i = 32'h0;
        sel_i = 4'hf;
        op_cause_i = 4'h0;
        n_fail = 0;
        checks_done = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_done_irq();
        t_causes();
        t_sticky();
        summarize();
    end
endmodule // tb_top
`default_nettype wire
